// File: bench/sfc_ctrl_sva.sv
// Port assertions for the serial flash controller
module sfc_ctrl_sva (
  input logic        sys_clk,
  input logic        rst_n,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        flash_cs_n,
  input logic        flash_sck,
  input logic        flash_si,
  input logic        flash_so
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        sck_d;   // Clock a cycle ago
  logic        cs_d;    // Select a cycle ago
  logic        pend_q;  // Self-timed work not yet seen done
  logic [7:0]  sh_q;    // Input shifter
  logic [7:0]  opc_q;   // Opcode of the frame
  logic [15:0] nb_q;    // Bits in the frame
  wire         rise = flash_sck & ~sck_d & ~flash_cs_n;
  wire         load = opc_q == 8'h84 || opc_q == 8'h87;
  wire         pgm  = opc_q == 8'h50 || (opc_q[7:4] == 4'h8 && !load);
  // Follow frames, opcodes and ready replies
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sck_d  <= 1'b0;
      cs_d   <= 1'b1;
      pend_q <= 1'b0;
      sh_q   <= 8'h00;
      opc_q  <= 8'h00;
      nb_q   <= 16'h0000;
    end
    else
    begin
      sck_d <= flash_sck;
      cs_d  <= flash_cs_n;
      if (flash_cs_n)
        nb_q <= 16'h0000;
      else if (rise)
        nb_q <= nb_q + 16'h0001;
      if (rise)
        sh_q <= {sh_q[6:0], flash_si};
      if (rise && nb_q == 16'h0007)
        opc_q <= {sh_q[6:0], flash_si};
      if (flash_cs_n && !cs_d && pgm)
        pend_q <= 1'b1;
      else if (rise && opc_q == 8'hD7 && nb_q[2:0] == 3'h0 && nb_q != 16'h0000 && flash_so)
        pend_q <= 1'b0;
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // Frame closed by the select rising
  sequence s_end;
    flash_cs_n && !cs_d;
  endsequence
  // Last opcode bit clocked in
  sequence s_opc;
    rise && nb_q == 16'h0007;
  endsequence
  AST_OPC_SET: assert property (s_opc |=>
    opc_q inside {8'h84, 8'h87, 8'h83, 8'h86, 8'h88, 8'h89, 8'h81, 8'h50, 8'hD7}) else $error("bad opcode");
  AST_PGM_LEN: assert property ((s_end ##0 (pgm && opc_q != 8'h50)) |-> nb_q == 16'h0020)
    else $error("page frame length");
  AST_BLK_LEN: assert property ((s_end ##0 opc_q == 8'h50) |-> nb_q == 16'h0020)
    else $error("block frame length");
  AST_LOAD_LEN: assert property ((s_end ##0 load) |-> nb_q > 16'h0020 && nb_q[2:0] == 3'h0)
    else $error("load frame length");
  AST_BUSY_WAIT: assert property (s_opc |=> opc_q == 8'hD7 || !pend_q)
    else $error("command while busy");
  AST_SEL_LOW: assert property ($fell(flash_cs_n) |-> !flash_sck)
    else $error("clock high at select");
  AST_RDY_PULSE: assert property ((psel && penable && !pready) |=> pready ##1 !pready)
    else $error("ready not a single pulse after one wait state");
  AST_ERR_MAP: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10}))
    else $error("wrong error response");
endmodule
bind sfc_ctrl sfc_ctrl_sva u_sva (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .flash_cs_n(flash_cs_n), .flash_sck(flash_sck), .flash_si(flash_si), .flash_so(flash_so));

// File: bench/sfc_ctrl_test.sv
// Self-checking bench for the serial flash controller
`include "sfc_defines.vh"
module sfc_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;                         // System clock
  logic        rst_n = 1'b0;                           // Reset
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // Bus controls
  logic [7:0]  paddr = 8'h00;                          // Address
  logic [31:0] pwdata = 32'h0;                         // Write data
  logic [31:0] prdata;                                 // Read data
  logic        pready, pslverr;                        // Answer
  wire         flash_cs_n, flash_sck, flash_si, flash_so; // Link
  int          n_fail = 0;                             // Mismatches
  int          compares = 0;                           // Comparisons
  // Clock at 8 ns
  always #4 sys_clk = ~sys_clk;
  sfc_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_cs_n(flash_cs_n), .flash_sck(flash_sck), .flash_si(flash_si), .flash_so(flash_so));
  sfc_flash_model flash (.flash_cs_n(flash_cs_n), .flash_sck(flash_sck), .flash_si(flash_si),
    .flash_so(flash_so));
  // Verdict and end of run
  task automatic final_report;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Hung wait
  task automatic give_up;
    n_fail++;
    $display("ERROR %0t timeout", $time);
    final_report();
  endtask
  // One bus transfer, held until ready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge sys_clk);
      if (pready === 1'b1)
        break;
    end
    if (i == 50)
      give_up();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Poll a status bit until it reads v
  task automatic wait_stat(input int b, input logic v);
    logic [31:0] rd;
    logic        e;
    int          i;
    for (i = 0; i < 3000; i++)
    begin
      apb(1'b0, `SFC_REG_STAT, 32'h0, rd, e);
      if (rd[b] === v)
        break;
    end
    if (i == 3000)
      give_up();
  endtask
  // Issue a command and judge the frame the device saw
  task automatic run(input logic [2:0] cmd, input logic b2, input logic p256,
                     input logic [11:0] pg, input logic [8:0] ix, input int nd);
    logic [31:0] rd;
    logic        e;
    logic [23:0] ad, mk;
    logic [7:0]  op;
    int          k;
    apb(1'b1, `SFC_REG_ADDR, {4'h0, pg, 7'h00, ix}, rd, e);
    apb(1'b1, `SFC_REG_CTRL, {26'h0, p256, b2, cmd, 1'b1}, rd, e);
    for (k = 0; k < nd; k++)
    begin
      wait_stat(`SFC_STAT_DREQ_BIT, 1'b1);
      apb(1'b1, `SFC_REG_DATA, {24'h0, 8'hA0 + k[7:0]}, rd, e);
    end
    if (cmd == 3'h0)
      apb(1'b1, `SFC_REG_CTRL, 32'h40, rd, e);
    wait_stat(`SFC_STAT_BUSY_BIT, 1'b0);
    case (cmd)
      3'h0: op = b2 ? 8'h87 : 8'h84;
      3'h1: op = b2 ? 8'h86 : 8'h83;
      3'h2: op = b2 ? 8'h89 : 8'h88;
      3'h3: op = 8'h81;
      default: op = 8'h50;
    endcase
    ad = p256 ? {4'h0, pg, 8'h00} : {3'h0, pg, 9'h000};
    mk = p256 ? 24'h0FFF00 : 24'h1FFE00;
    if (cmd == 3'h4)
      mk = p256 ? 24'h0FF800 : 24'h1FF000;
    if (cmd == 3'h0)
    begin
      ad = {15'h0, ix};
      mk = p256 ? 24'h0000FF : 24'h0001FF;
    end
    check(flash.lf[0], op);
    check({flash.lf[1], flash.lf[2], flash.lf[3]} & mk, ad & mk);
    check(flash.lfn, 4 + nd);
    for (k = 0; k < nd; k++)
      check(flash.lf[4 + k], 8'hA0 + k[7:0]);
  endtask
  // Register read-back, divider reset value and an unmapped read
  task automatic sc_regs;
    logic [31:0] rd;
    logic        e;
    apb(1'b0, `SFC_REG_DIV, 32'h0, rd, e);
    check(rd, {24'h0, `SFC_DIV_RESET});
    apb(1'b1, `SFC_REG_DIV, 32'h00000007, rd, e);
    apb(1'b0, `SFC_REG_DIV, 32'h0, rd, e);
    check(rd, 32'h00000007);
    apb(1'b1, `SFC_REG_DIV, {24'h0, `SFC_DIV_RESET}, rd, e);
    apb(1'b1, `SFC_REG_ADDR, 32'h05A301A5, rd, e);
    apb(1'b0, `SFC_REG_ADDR, 32'h0, rd, e);
    check(rd, 32'h05A301A5);
    apb(1'b0, 8'h14, 32'h0, rd, e);
    check(e, 1'b1);
  endtask
  // Loads into buffer 1 in the 264 setting and buffer 2 in the 256 setting
  task automatic sc_load;
    run(3'h0, 1'b0, 1'b0, 12'h000, 9'h1A5, 3);
    run(3'h0, 1'b1, 1'b1, 12'h000, 9'h0FF, 2);
  endtask
  // Both program kinds, both buffers and settings; plain program hits an erased page
  task automatic sc_program;
    int b, p;
    for (b = 0; b < 2; b++)
      for (p = 0; p < 2; p++)
      begin
        run(3'h1, b[0], p[0], 12'hFFF, 9'h000, 0);
        run(3'h3, 1'b0, p[0], 12'h5A3, 9'h000, 0);
        run(3'h2, b[0], p[0], 12'h5A3, 9'h000, 0);
      end
  endtask
  // Page and block erase back to back, busy respected
  task automatic sc_erase;
    int p;
    for (p = 0; p < 2; p++)
    begin
      run(3'h3, 1'b0, p[0], 12'h001, 9'h000, 0);
      run(3'h4, 1'b0, p[0], 12'h7F5, 9'h000, 0);
    end
    check(flash.viol, 1'b0);
  endtask
  // Main sequence
  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    sc_regs();
    sc_load();
    sc_program();
    sc_erase();
    final_report();
  end
endmodule

// File: bench/sfc_flash_model.sv
// Flash device model: logs frames, answers status reads
module sfc_flash_model (
  input wire   flash_cs_n,
  input wire   flash_sck,
  input wire   flash_si,
  output logic flash_so
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh = 8'h00;  // Input shifter
  logic [7:0] fb [0:15];   // Current frame
  logic [7:0] lf [0:15];   // Last command frame
  int         nb = 0;      // Bytes in frame
  int         nbit = 0;    // Bits in frame
  int         lfn = 0;     // Bytes in last command
  int         busy = 0;    // Busy replies left
  logic       viol = 1'b0; // Command sent while busy
  initial flash_so = 1'b0;
  // New frame
  always @(negedge flash_cs_n)
  begin
    nb = 0;
    nbit = 0;
  end
  // Sample input on the rising clock
  always @(posedge flash_sck)
  begin
    if (!flash_cs_n)
    begin
      sh = {sh[6:0], flash_si};
      nbit++;
      if (nbit % 8 == 0)
      begin
        if (nb < 16)
          fb[nb] = sh;
        if (nb == 0 && sh != 8'hD7 && busy > 0)
          viol = 1'b1;
        nb++;
      end
    end
  end
  // Status reply: ready first, then a changing pattern
  always @(negedge flash_sck)
  begin
    if (!flash_cs_n && nb > 0 && fb[0] == 8'hD7)
    begin
      if (nbit % 8 == 0)
      begin
        flash_so = busy == 0;
        if (busy > 0)
          busy--;
      end
      else
        flash_so = ~flash_so;
    end
  end
  // Frame end starts self-timed work for frames other than status reads and loads (84H, 87H) and inverts the output
  always @(posedge flash_cs_n)
  begin
    flash_so = ~flash_so;
    if (nb > 0 && fb[0] != 8'hD7)
    begin
      lf = fb;
      lfn = nb;
      if (fb[0] != 8'h84 && fb[0] != 8'h87)
        busy = 3;
    end
  end
endmodule

// File: rtl/sfc_ctrl.v
// Serial flash program and erase controller with APB command registers
// Summary of operation
// - Load opcode 84H or 87H, three address bytes
// - 264 setting: 15 ignored, nine index bits
// - 256 setting: 16 ignored, eight index bits
// - Program with erase: 83H or 86H
// - 264: three ignored, page, nine ignored
// - 256: four ignored, page, eight ignored
// - Program without erase: 88H or 89H
// - Host erases target page beforehand
// - Page erase 81H, page format
// - Block erase 50H, 264 block layout
// - 256 block layout: bits 19 to 11
//
// The placing of the registers and register access over APB were chosen for this implementation.
`include "sfc_defines.vh"
module sfc_ctrl (
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         flash_cs_n,
  output reg         flash_sck,
  output reg         flash_si,
  input  wire        flash_so
);
  // Sequencer states
  localparam ST_IDLE = 3'h0;
  localparam ST_OP   = 3'h1;
  localparam ST_ADR  = 3'h2;
  localparam ST_DATA = 3'h3;
  localparam ST_POLL = 3'h4;
  localparam ST_PRD  = 3'h5;
  localparam ST_GAP  = 3'h6;

  reg  [2:0]  st_q;          // Sequencer state
  reg  [2:0]  cmd_q;         // Command kind
  reg         buf_q;         // Second buffer selected
  reg         p256_q;        // 256-byte page setting
  reg         end_q;         // Software asks to end the load
  reg  [11:0] page_q;        // Page number
  reg  [8:0]  idx_q;         // Buffer byte index
  reg  [7:0]  data_q;        // Next load byte
  reg         dval_q;        // Load byte waiting
  reg  [7:0]  div_q;         // Serial half period
  reg  [1:0]  acnt_q;        // Address bytes sent
  reg         fbusy_q;       // Flash still busy
  reg         start_q;       // Shifter start pulse
  reg  [7:0]  txb_q;         // Byte to shift
  reg         shf_q;         // Shifter holds a byte in flight
  reg  [2:0]  so_sync_q;     // Serial output synchroniser
  reg         so_q;          // Filtered serial output
  reg  [23:0] adr_w;         // Assembled address
  reg  [7:0]  op_w;          // Selected opcode
  wire        sck_w;
  wire        si_w;
  wire        done_w;
  wire [7:0]  rx_w;
  wire        acc_w = psel && penable;  // APB access phase

  // Byte shifter
  sfc_shifter u_shift (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .half_div (div_q),
    .start    (start_q),
    .tx_byte  (txb_q),
    .miso_in  (so_q),
    .sck_q    (sck_w),
    .mosi_q   (si_w),
    .done_q   (done_w),
    .rx_q     (rx_w)
  );

  // Opcode and address layout per command and page setting
  always @*
  begin
    adr_w = 24'h000000;
    op_w  = `SFC_OP_PAGE_ERASE;
    case (cmd_q)
      `SFC_CMD_LOAD:
      begin
        op_w = buf_q ? `SFC_OP_BUF2_LOAD : `SFC_OP_BUF1_LOAD;
        if (p256_q)
          adr_w = {16'h0000, idx_q[7:0]};
        else
          adr_w = {15'h0000, idx_q};
      end
      `SFC_CMD_PGM_ER, `SFC_CMD_PGM, `SFC_CMD_PAGE_ERASE:
      begin
        if (cmd_q == `SFC_CMD_PGM_ER)
          op_w = buf_q ? `SFC_OP_BUF2_PGM_ER : `SFC_OP_BUF1_PGM_ER;
        else if (cmd_q == `SFC_CMD_PGM)
          op_w = buf_q ? `SFC_OP_BUF2_PGM : `SFC_OP_BUF1_PGM;
        else
          op_w = `SFC_OP_PAGE_ERASE;
        if (p256_q)
          adr_w = {4'h0, page_q, 8'h00};
        else
          adr_w = {3'h0, page_q, 9'h000};
      end
      `SFC_CMD_BLOCK_ERASE:
      begin
        op_w = `SFC_OP_BLOCK_ERASE;
        if (p256_q)
          adr_w = {4'h0, page_q[11:3], 11'h000};
        else
          adr_w = {3'h0, page_q[11:3], 12'h000};
      end
      default:
      begin
        op_w  = `SFC_OP_PAGE_ERASE;
        adr_w = 24'h000000;
      end
    endcase
  end

  // Three-stage synchroniser on the serial output pin
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      so_sync_q <= 3'h0;
      so_q      <= 1'b0;
    end
    else
    begin
      so_sync_q <= {so_sync_q[1:0], flash_so};
      if (so_sync_q[1] == so_sync_q[2])
        so_q <= so_sync_q[2];
    end
  end

  // APB slave, register file and sequencer
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q       <= ST_IDLE;
      cmd_q      <= `SFC_CMD_LOAD;
      buf_q      <= 1'b0;
      p256_q     <= 1'b0;
      end_q      <= 1'b0;
      page_q     <= 12'h000;
      idx_q      <= 9'h000;
      data_q     <= 8'h00;
      dval_q     <= 1'b0;
      div_q      <= `SFC_DIV_RESET;
      acnt_q     <= 2'h0;
      fbusy_q    <= 1'b0;
      start_q    <= 1'b0;
      txb_q      <= 8'h00;
      shf_q      <= 1'b0;
      prdata     <= 32'h00000000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      flash_cs_n <= 1'b1;
      flash_sck  <= 1'b0;
      flash_si   <= 1'b0;
    end
    else
    begin
      start_q   <= 1'b0;
      flash_sck <= sck_w;
      flash_si  <= si_w;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      // Track the byte in flight from start pulse to done pulse
      if (start_q)
        shf_q <= 1'b1;
      else if (done_w)
        shf_q <= 1'b0;
      // One wait state: answer in the second access cycle
      if (acc_w && !pready)
      begin
        pready <= 1'b1;
        prdata <= 32'h00000000;
        case (paddr)
          `SFC_REG_CTRL:
          begin
            if (pwrite)
            begin
              if (st_q == ST_IDLE && pwdata[`SFC_CTRL_GO_BIT])
              begin
                cmd_q  <= pwdata[`SFC_CTRL_CMD_MSB:`SFC_CTRL_CMD_LSB];
                buf_q  <= pwdata[`SFC_CTRL_BUF_BIT];
                p256_q <= pwdata[`SFC_CTRL_P256_BIT];
                end_q  <= 1'b0;
                st_q   <= ST_OP;
              end
              else if (st_q != ST_IDLE && pwdata[`SFC_CTRL_END_BIT])
                end_q <= 1'b1;
            end
            else
              prdata <= {26'h0, p256_q, buf_q, cmd_q, 1'b0};
          end
          `SFC_REG_ADDR:
          begin
            if (pwrite)
            begin
              if (st_q == ST_IDLE)
              begin
                page_q <= pwdata[`SFC_ADDR_PAGE_MSB:`SFC_ADDR_PAGE_LSB];
                idx_q  <= pwdata[`SFC_ADDR_IDX_MSB:0];
              end
            end
            else
              prdata <= {4'h0, page_q, 7'h00, idx_q};
          end
          `SFC_REG_DATA:
          begin
            if (pwrite)
            begin
              data_q <= pwdata[7:0];
              dval_q <= 1'b1;
            end
          end
          `SFC_REG_STAT:
            if (!pwrite)
              prdata <= {29'h0, (st_q == ST_DATA) && !dval_q, fbusy_q, st_q != ST_IDLE};
          `SFC_REG_DIV:
          begin
            if (pwrite)
              div_q <= (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
            else
              prdata <= {24'h0, div_q};
          end
          default:
            pslverr <= 1'b1;
        endcase
      end
      // Sequencer
      case (st_q)
        ST_IDLE:
          flash_cs_n <= 1'b1;
        ST_OP:
        begin
          if (flash_cs_n)
          begin
            // Wait for the flash to be ready before a new command
            flash_cs_n <= 1'b0;
            start_q    <= 1'b1;
            txb_q      <= `SFC_OP_STATUS_READ;
            st_q       <= ST_POLL;
          end
        end
        ST_POLL:
          if (done_w)
          begin
            start_q <= 1'b1;
            txb_q   <= 8'h00;
            st_q    <= ST_PRD;
          end
        ST_PRD:
          if (done_w)
          begin
            if (rx_w[`SFC_STAT_READY_BIT])
            begin
              fbusy_q    <= 1'b0;
              flash_cs_n <= 1'b1;
              st_q       <= ST_GAP;
            end
            else
            begin
              fbusy_q <= 1'b1;
              start_q <= 1'b1;
            end
          end
        ST_GAP:
        begin
          // Select high for one cycle then send the opcode
          flash_cs_n <= 1'b0;
          start_q    <= 1'b1;
          txb_q      <= op_w;
          acnt_q     <= 2'h0;
          st_q       <= ST_ADR;
        end
        ST_ADR:
          if (done_w)
          begin
            acnt_q <= acnt_q + 2'h1;
            if (acnt_q == `SFC_ADR_LAST)
            begin
              if (cmd_q == `SFC_CMD_LOAD)
                st_q <= ST_DATA;
              else
              begin
                // Select rise starts the self-timed operation
                flash_cs_n <= 1'b1;
                fbusy_q    <= 1'b1;
                st_q       <= ST_IDLE;
              end
            end
            else
            begin
              start_q <= 1'b1;
              case (acnt_q)
                2'h0:    txb_q <= adr_w[23:16];
                2'h1:    txb_q <= adr_w[15:8];
                default: txb_q <= adr_w[7:0];
              endcase
            end
          end
        ST_DATA:
        begin
          // Stream bytes while select low; device wraps the index
          if (!start_q && !shf_q && dval_q)
          begin
            start_q <= 1'b1;
            txb_q   <= data_q;
            // A byte written in this very cycle stays pending
            dval_q  <= acc_w && !pready && pwrite && (paddr == `SFC_REG_DATA);
          end
          else if (end_q && !dval_q && !start_q && !shf_q)
          begin
            flash_cs_n <= 1'b1;
            st_q       <= ST_IDLE;
          end
        end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end
endmodule

// File: rtl/sfc_defines.vh
// Constants for the serial flash program and erase controller
`ifndef SFC_DEFINES_VH
`define SFC_DEFINES_VH
// Flash instruction codes
`define SFC_OP_BUF1_LOAD    8'h84
`define SFC_OP_BUF2_LOAD    8'h87
`define SFC_OP_BUF1_PGM_ER  8'h83
`define SFC_OP_BUF2_PGM_ER  8'h86
`define SFC_OP_BUF1_PGM     8'h88
`define SFC_OP_BUF2_PGM     8'h89
`define SFC_OP_PAGE_ERASE   8'h81
`define SFC_OP_BLOCK_ERASE  8'h50
`define SFC_OP_STATUS_READ  8'hD7
// Status register ready bit position
`define SFC_STAT_READY_BIT  7
// Command kinds written by software
`define SFC_CMD_LOAD        3'h0
`define SFC_CMD_PGM_ER      3'h1
`define SFC_CMD_PGM         3'h2
`define SFC_CMD_PAGE_ERASE  3'h3
`define SFC_CMD_BLOCK_ERASE 3'h4
// APB register byte offsets
`define SFC_REG_CTRL        8'h00
`define SFC_REG_ADDR        8'h04
`define SFC_REG_DATA        8'h08
`define SFC_REG_STAT        8'h0C
`define SFC_REG_DIV         8'h10
// Control register fields
`define SFC_CTRL_GO_BIT     0
`define SFC_CTRL_CMD_LSB    1
`define SFC_CTRL_CMD_MSB    3
`define SFC_CTRL_BUF_BIT    4
`define SFC_CTRL_P256_BIT   5
`define SFC_CTRL_END_BIT    6
// Status register fields
`define SFC_STAT_BUSY_BIT   0
`define SFC_STAT_FBUSY_BIT  1
`define SFC_STAT_DREQ_BIT   2
// Address register fields
`define SFC_ADDR_PAGE_MSB   27
`define SFC_ADDR_PAGE_LSB   16
`define SFC_ADDR_IDX_MSB    8
// Count of the last of the three address bytes
`define SFC_ADR_LAST        2'h3
// Divider reset value (half period of serial clock in cycles, less one)
`define SFC_DIV_RESET       8'h04
`endif

// File: rtl/sfc_shifter.v
// Byte shifter for the serial link, mode 0, clocked by divider enables
`include "sfc_defines.vh"
module sfc_shifter (
  input  wire       sys_clk,
  input  wire       rst_n,
  input  wire [7:0] half_div,   // Half period of serial clock in sys_clk cycles, less one
  input  wire       start,      // Pulse: shift one byte
  input  wire [7:0] tx_byte,    // Byte to send, MSB first
  input  wire       miso_in,    // Synchronised serial output of the flash
  output reg        sck_q,      // Serial clock
  output reg        mosi_q,     // Serial input of the flash
  output reg        done_q,     // Pulse: byte finished
  output reg  [7:0] rx_q        // Byte received
);
  reg [7:0] cnt_q;              // Divider count
  reg [3:0] bit_q;              // Bits left
  reg [7:0] sh_q;               // Transmit shift
  reg       act_q;              // Byte in flight
  wire      tick = act_q && (cnt_q == 8'h00);  // Half period enable pulse

  // Divider, shifting on falling and sampling on rising serial edges
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q  <= 8'h00;
      bit_q  <= 4'h0;
      sh_q   <= 8'h00;
      act_q  <= 1'b0;
      sck_q  <= 1'b0;
      mosi_q <= 1'b0;
      done_q <= 1'b0;
      rx_q   <= 8'h00;
    end
    else
    begin
      done_q <= 1'b0;
      if (start && !act_q)
      begin
        // Present the first bit before the first rising edge
        act_q  <= 1'b1;
        bit_q  <= 4'h8;
        mosi_q <= tx_byte[7];
        sh_q   <= {tx_byte[6:0], 1'b0};
        cnt_q  <= half_div;
      end
      else if (act_q)
      begin
        cnt_q <= tick ? half_div : cnt_q - 8'h01;
        if (tick)
        begin
          sck_q <= ~sck_q;
          if (!sck_q)
            rx_q <= {rx_q[6:0], miso_in};   // Rising edge: sample
          else
          begin
            // Falling edge: next bit or finish
            bit_q  <= bit_q - 4'h1;
            mosi_q <= sh_q[7];
            sh_q   <= {sh_q[6:0], 1'b0};
            if (bit_q == 4'h1)
            begin
              act_q  <= 1'b0;
              done_q <= 1'b1;
            end
          end
        end
      end
    end
  end
endmodule
